/* File: event_group.sv */
// one latched event register with its enable mask and summary
`timescale 1ns/1ps
module event_group #(
    parameter int                 W         = 16,
    parameter logic [W-1:0]       IMPL_MASK = '1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [W-1:0]     set_in,
    input  wire logic             clear,
    input  wire logic             en_write,
    input  wire logic [W-1:0]     en_wdata,
    output logic      [W-1:0]     event_q,
    output logic      [W-1:0]     enable_q,
    output logic                  summary
);

    logic [W-1:0] next_event;
    logic [W-1:0] next_enable;

    always_comb begin
        // bits latch; a set in the clearing cycle survives
        next_event  = ((clear ? '0 : event_q) | set_in) & IMPL_MASK;
        // only an explicit write moves the mask
        next_enable = en_write ? en_wdata : enable_q;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            event_q  <= W'(status_event_pkg::EVENT_RESET);
            enable_q <= W'(status_event_pkg::ENABLE_RESET);
        end else begin
            event_q  <= next_event;
            enable_q <= next_enable;
        end
    end

    // live, so it drops as soon as events or enables are cleared
    assign summary = |(event_q & enable_q);

endmodule : event_group

/* File: regulation_monitor.sv */
// live regulation condition of one output and its loss events
`timescale 1ns/1ps
module regulation_monitor (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [1:0]  mode_in,
    output logic      [1:0]  cond_q,
    output logic      [1:0]  loss
);

    logic [1:0] next_cond;

    always_comb begin
        next_cond = mode_in;
        loss      = 2'h0;
        // leaving a regulated mode for anything but off is a loss
        loss[status_event_pkg::VOLT_LOSS_BIT] = (cond_q == status_event_pkg::MODE_CV) &&
                                               (mode_in != status_event_pkg::MODE_CV) &&
                                               (mode_in != status_event_pkg::MODE_OFF);
        loss[status_event_pkg::CURR_LOSS_BIT] = (cond_q == status_event_pkg::MODE_CC) &&
                                               (mode_in != status_event_pkg::MODE_CC) &&
                                               (mode_in != status_event_pkg::MODE_OFF);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cond_q <= status_event_pkg::COND_RESET;
        end else begin
            cond_q <= next_cond;
        end
    end

endmodule : regulation_monitor

/* File: status_event_hierarchy.sv */
// questionable status hierarchy: per-output regulation, output summary, questionable
`timescale 1ns/1ps
module status_event_hierarchy #(
    parameter int                        N_OUT = status_event_pkg::NUM_OUTPUTS
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire status_event_pkg::reg_cmd_t cmd,
    input  wire logic                    clear_status,
    input  wire logic [N_OUT-1:0][1:0]   output_mode,
    output status_event_pkg::reg_rsp_t   rsp,
    output logic                         status_byte_questionable_group
);

    localparam int W = status_event_pkg::REG_W;

    // index of register n in a per-output bank
    function automatic logic [3:0] bank_index(input logic [3:0] base, input int n);
        bank_index = 4'(int'(base) + n);
    endfunction : bank_index

    function automatic logic hit(input status_event_pkg::reg_cmd_t c, input logic wr,
                                 input logic [3:0] idx);
        hit = c.valid && (c.write == wr) && (c.index == idx);
    endfunction : hit

    logic [W-1:0]     questionable_group_event;
    logic [W-1:0]     questionable_group_enable;
    logic [W-1:0]     questionable_group_set;
    logic             questionable_group_clear;
    logic             questionable_group_summary;
    logic [W-1:0]     inst_event;
    logic [W-1:0]     inst_enable;
    logic [W-1:0]     inst_set;
    logic             inst_clear;
    logic             inst_summary;
    logic [W-1:0]     reg_event   [N_OUT];
    logic [W-1:0]     reg_enable  [N_OUT];
    logic [W-1:0]     reg_set     [N_OUT];
    logic             reg_clear   [N_OUT];
    logic [N_OUT-1:0] reg_summary;
    logic [1:0]       reg_cond    [N_OUT];
    logic [1:0]       reg_loss    [N_OUT];

    status_event_pkg::reg_rsp_t next_rsp;
    logic                       next_status_byte_questionable_group;

    // clearing reads and clear-status only; resets of the instrument have no path here
    always_comb begin
        questionable_group_clear = clear_status ||
                     hit(cmd, 1'b0, status_event_pkg::IDX_QUESTIONABLE_GROUP_EVENT);
        inst_clear = clear_status ||
                     hit(cmd, 1'b0, status_event_pkg::IDX_INST_EVENT);
    end

    // one regulation set per output
    for (genvar n = 0; n < N_OUT; n++) begin : g_out
        regulation_monitor u_mon (
            .clk_sys (clk_sys),
            .rst     (rst),
            .mode_in (output_mode[n]),
            .cond_q  (reg_cond[n]),
            .loss    (reg_loss[n])
        );

        always_comb begin
            reg_set[n]   = {{(W-2){1'b0}}, reg_loss[n]};
            reg_clear[n] = clear_status ||
                           hit(cmd, 1'b0, bank_index(status_event_pkg::IDX_REG_EVENT, n));
        end

        event_group #(
            .W         (W),
            .IMPL_MASK (status_event_pkg::REG_IMPL_MASK)
        ) u_reg (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .set_in    (reg_set[n]),
            .clear     (reg_clear[n]),
            .en_write  (hit(cmd, 1'b1, bank_index(status_event_pkg::IDX_REG_ENABLE, n))),
            .en_wdata  (cmd.wdata),
            .event_q   (reg_event[n]),
            .enable_q  (reg_enable[n]),
            .summary   (reg_summary[n])
        );
    end

    always_comb begin
        inst_set = '0;
        for (int n = 0; n < N_OUT; n++) begin
            inst_set[status_event_pkg::FIRST_OUTPUT_BIT + n] = reg_summary[n];
        end
        questionable_group_set = '0;
        questionable_group_set[status_event_pkg::QUESTIONABLE_GROUP_SUMMARY_BIT] = inst_summary;
    end

    event_group #(
        .W         (W),
        .IMPL_MASK (status_event_pkg::INST_IMPL_MASK)
    ) u_inst (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .set_in    (inst_set),
        .clear     (inst_clear),
        .en_write  (hit(cmd, 1'b1, status_event_pkg::IDX_INST_ENABLE)),
        .en_wdata  (cmd.wdata),
        .event_q   (inst_event),
        .enable_q  (inst_enable),
        .summary   (inst_summary)
    );

    // only bit 13 is implemented; the mask keeps the rest at zero
    event_group #(
        .W         (W),
        .IMPL_MASK (status_event_pkg::QUESTIONABLE_GROUP_IMPL_MASK)
    ) u_questionable_group (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .set_in    (questionable_group_set),
        .clear     (questionable_group_clear),
        .en_write  (hit(cmd, 1'b1, status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE)),
        .en_wdata  (cmd.wdata),
        .event_q   (questionable_group_event),
        .enable_q  (questionable_group_enable),
        .summary   (questionable_group_summary)
    );

    // read data is the value before the clear; writes to read-only indices are dropped
    always_comb begin
        next_rsp.valid = cmd.valid && !cmd.write;
        next_rsp.data  = status_event_pkg::READ_ZERO;
        if (cmd.index == status_event_pkg::IDX_QUESTIONABLE_GROUP_EVENT) begin
            next_rsp.data = questionable_group_event;
        end else if (cmd.index == status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE) begin
            next_rsp.data = questionable_group_enable;
        end else if (cmd.index == status_event_pkg::IDX_INST_EVENT) begin
            next_rsp.data = inst_event;
        end else if (cmd.index == status_event_pkg::IDX_INST_ENABLE) begin
            next_rsp.data = inst_enable;
        end else begin
            for (int n = 0; n < N_OUT; n++) begin
                if (cmd.index == bank_index(status_event_pkg::IDX_REG_EVENT, n)) begin
                    next_rsp.data = reg_event[n];
                end else if (cmd.index == bank_index(status_event_pkg::IDX_REG_COND, n)) begin
                    next_rsp.data = {{(W-2){1'b0}}, reg_cond[n]};
                end else if (cmd.index == bank_index(status_event_pkg::IDX_REG_ENABLE, n)) begin
                    next_rsp.data = reg_enable[n];
                end
            end
        end
        if (cmd.write) begin
            next_rsp.data = status_event_pkg::READ_ZERO;
        end
        // registered copy lags the live summary by one cycle
        next_status_byte_questionable_group = questionable_group_summary;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsp              <= '0;
            status_byte_questionable_group <= 1'b0;
        end else begin
            rsp              <= next_rsp;
            status_byte_questionable_group <= next_status_byte_questionable_group;
        end
    end

    // checks on output 0 stand for all outputs; the logic is one generate
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic rd_reg0;
    logic rd_questionable_group_en;
    logic rd_questionable_group_ev;
    logic rd_cond0;
    logic wr_questionable_group_en;
    logic wr_questionable_group_zero;
    assign rd_reg0      = hit(cmd, 1'b0, status_event_pkg::IDX_REG_EVENT);
    assign rd_questionable_group_en   = hit(cmd, 1'b0, status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE);
    assign rd_questionable_group_ev   = hit(cmd, 1'b0, status_event_pkg::IDX_QUESTIONABLE_GROUP_EVENT);
    assign rd_cond0     = hit(cmd, 1'b0, status_event_pkg::IDX_REG_COND);
    assign wr_questionable_group_en   = hit(cmd, 1'b1, status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE);
    // a zero write or a reset is the only way this mask goes back to zero
    assign wr_questionable_group_zero = wr_questionable_group_en && (cmd.wdata == status_event_pkg::READ_ZERO);

    sequence s_cv_held;
        output_mode[0] == status_event_pkg::MODE_CV;
    endsequence

    sequence s_to_cc;
        output_mode[0] == status_event_pkg::MODE_CC;
    endsequence

    sequence s_cc_held;
        output_mode[0] == status_event_pkg::MODE_CC;
    endsequence

    sequence s_to_cv;
        output_mode[0] == status_event_pkg::MODE_CV;
    endsequence

    chk_event_latch_hold: assert property (
        (reg_event[0][0] && !reg_clear[0]) |=> reg_event[0][0])
        else $error("regulation event bit dropped without a clear");

    chk_read_clears_bits: assert property (
        rd_reg0 |=> (reg_event[0] == ($past(reg_set[0]) & status_event_pkg::REG_IMPL_MASK)))
        else $error("read of regulation event did not clear it");

    chk_cls_clears_events: assert property (
        (clear_status && !cmd.valid) |=> (questionable_group_event == $past(questionable_group_set)) &&
                                        $stable(questionable_group_enable) && $stable(inst_enable) &&
                                        $stable(reg_enable[0]))
        else $error("clear-status wrong on events or enables");

    chk_enable_read_value: assert property (
        rd_questionable_group_en |=> rsp.valid && (rsp.data == $past(questionable_group_enable)) && $stable(questionable_group_enable))
        else $error("enable read returned wrong value or changed it");

    chk_summary_or_enabled: assert property (
        reg_summary[0] == |(reg_event[0] & reg_enable[0]))
        else $error("regulation summary not OR of enabled events");

    chk_questionable_group_unused_zero: assert property (
        (questionable_group_event & ~status_event_pkg::QUESTIONABLE_GROUP_IMPL_MASK) == status_event_pkg::READ_ZERO)
        else $error("unimplemented questionable bit set");

    chk_inst_bit_feed: assert property (
        (reg_summary[0] && !inst_clear) |=> inst_event[status_event_pkg::FIRST_OUTPUT_BIT])
        else $error("output summary bit 1 not set from output one");

    chk_questionable_group_bit_feed: assert property (
        inst_summary |=> questionable_group_event[status_event_pkg::QUESTIONABLE_GROUP_SUMMARY_BIT])
        else $error("questionable bit 13 not set from output summary");

    chk_status_byte_bit: assert property (
        status_byte_questionable_group == $past(questionable_group_summary))
        else $error("status byte bit does not follow questionable summary");

    chk_voltage_loss_set: assert property (
        s_cv_held ##1 s_to_cc |=> reg_event[0][status_event_pkg::VOLT_LOSS_BIT])
        else $error("voltage regulation loss not latched");

    chk_cond_live_mode: assert property (
        ##1 reg_cond[0] == $past(output_mode[0]))
        else $error("condition does not follow live mode");

    chk_questionable_group_enable_zero: assert property (
        wr_questionable_group_zero |=> (questionable_group_enable == status_event_pkg::READ_ZERO))
        else $error("questionable enable not cleared by zero write");

    chk_questionable_group_enable_hold: assert property (
        !wr_questionable_group_en |=> $stable(questionable_group_enable))
        else $error("questionable enable moved without a write");

    chk_enable_write_lands: assert property (
        wr_questionable_group_en |=> (questionable_group_enable == $past(cmd.wdata)))
        else $error("questionable enable write did not land");

    chk_current_loss_set: assert property (
        s_cc_held ##1 s_to_cv |=> reg_event[0][status_event_pkg::CURR_LOSS_BIT])
        else $error("current regulation loss not latched");

    // quiet cycles must leave the latched bits alone, whatever else is written
    chk_event_no_change: assert property (
        (!reg_clear[0] && (reg_loss[0] == 2'h0)) |=> $stable(reg_event[0]))
        else $error("regulation event changed with no event or clear");

    chk_questionable_group_read_clears: assert property (
        rd_questionable_group_ev |=> (rsp.data == $past(questionable_group_event)) &&
                       (questionable_group_event == ($past(questionable_group_set) & status_event_pkg::QUESTIONABLE_GROUP_IMPL_MASK)))
        else $error("questionable event read wrong or not cleared");

    chk_cond_read_value: assert property (
        rd_cond0 |=> (rsp.data == {{(W-2){1'b0}}, $past(reg_cond[0])}))
        else $error("condition read does not show live mode");

    chk_read_answer_once: assert property (
        (cmd.valid && !cmd.write) |=> rsp.valid)
        else $error("read got no answer");

    chk_write_no_answer: assert property (
        (!cmd.valid || cmd.write) |=> !rsp.valid)
        else $error("answer without a read");

    chk_inst_unused_zero: assert property (
        (inst_event & ~status_event_pkg::INST_IMPL_MASK) == status_event_pkg::READ_ZERO)
        else $error("unimplemented output summary bit set");

    chk_reg_unused_zero: assert property (
        (reg_event[0] & ~status_event_pkg::REG_IMPL_MASK) == status_event_pkg::READ_ZERO)
        else $error("unimplemented regulation event bit set");

endmodule : status_event_hierarchy

/* File: status_event_hierarchy_bench.sv */
// self-checking bench for the questionable status hierarchy
`timescale 1ns/1ps
module status_event_hierarchy_bench;
    localparam int                     N_OUT = status_event_pkg::NUM_OUTPUTS;
    logic                              clk_sys;
    logic                              rst;
    status_event_pkg::reg_cmd_t        cmd;
    logic                              clear_status;
    logic [N_OUT-1:0][1:0]             output_mode;
    status_event_pkg::reg_rsp_t        rsp;
    logic                              status_byte_questionable_group;
    int                                fail_count;
    int                                total_checks;
    int                                seed;
    logic [15:0]                       exp_q[$];
    logic [15:0]                       en_val[5];
    logic [3:0]                        en_idx[5];

    status_event_hierarchy #(.N_OUT(N_OUT)) i_dut (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .cmd              (cmd),
        .clear_status     (clear_status),
        .output_mode      (output_mode),
        .rsp              (rsp),
        .status_byte_questionable_group (status_byte_questionable_group)
    );

    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        cmd = '0;
        clear_status = 1'b0;
        output_mode = '0;
        seed = 32'h0489;
        fail_count = 0;
        total_checks = 0;
    end

    always #50 clk_sys = ~clk_sys;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic issue(input logic w, input logic [3:0] idx, input logic [15:0] wd);
        @(posedge clk_sys);
        clear_status <= 1'b0;
        cmd <= '{valid: 1'b1, write: w, index: idx, wdata: wd};
    endtask : issue

    task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
        exp_q.push_back(exp);
        issue(1'b0, idx, 16'h0000);
    endtask : rd

    task automatic wr(input logic [3:0] idx, input logic [15:0] wd);
        issue(1'b1, idx, wd);
    endtask : wr

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            cmd <= '0;
            clear_status <= 1'b0;
        end
    endtask : idle

    task automatic set_mode(input int n, input logic [1:0] m);
        @(posedge clk_sys);
        cmd <= '0;
        output_mode[n] <= m;
    endtask : set_mode

    task automatic sbq(input logic exp);
        @(negedge clk_sys);
        check("status_byte_questionable_group", {15'h0000, status_byte_questionable_group}, {15'h0000, exp});
    endtask : sbq

    // responses are matched in order against the notes left by the driver
    always @(negedge clk_sys) begin
        if (rst === 1'b0 && rsp.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("mismatch rsp.data expected none seen %h", rsp.data);
            end else begin
                check("rsp.data", rsp.data, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        fail_count++;
        $display("mismatch watchdog expected done seen hang");
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        // every index incl. unmapped 13..15 reads zero after reset
        for (int i = 0; i < 16; i++) rd(4'(i), 16'h0000);
        en_idx = '{status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE, status_event_pkg::IDX_INST_ENABLE,
                   status_event_pkg::IDX_REG_ENABLE, status_event_pkg::IDX_REG_ENABLE + 4'h1,
                   status_event_pkg::IDX_REG_ENABLE + 4'h2};
        for (int i = 0; i < 5; i++) begin
            en_val[i] = 16'($random(seed));
            wr(en_idx[i], en_val[i]);
        end
        // reading twice shows a read leaves enables as they were
        for (int i = 0; i < 10; i++) rd(en_idx[i % 5], en_val[i % 5]);
        wr(status_event_pkg::IDX_QUESTIONABLE_GROUP_EVENT, 16'hffff);
        wr(status_event_pkg::IDX_INST_EVENT, 16'hffff);
        wr(status_event_pkg::IDX_REG_EVENT, 16'hffff);
        wr(status_event_pkg::IDX_REG_COND, 16'hffff);
        rd(status_event_pkg::IDX_QUESTIONABLE_GROUP_EVENT, 16'h0000);
        rd(status_event_pkg::IDX_INST_EVENT, 16'h0000);
        rd(status_event_pkg::IDX_REG_EVENT, 16'h0000);
        rd(status_event_pkg::IDX_REG_COND, 16'h0000);
        wr(status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE, 16'h2000);
        wr(status_event_pkg::IDX_INST_ENABLE, 16'h000e);
        for (int n = 0; n < N_OUT; n++) begin
            wr(status_event_pkg::IDX_REG_ENABLE + 4'(n), 16'h0003);
        end
        for (int n = 0; n < N_OUT; n++) begin
            set_mode(n, status_event_pkg::MODE_CV);
            idle(2);
            rd(status_event_pkg::IDX_REG_COND + 4'(n), 16'h0002);
            rd(status_event_pkg::IDX_REG_EVENT + 4'(n), 16'h0000);
            set_mode(n, status_event_pkg::MODE_CC);
            idle(5);
            sbq(1'b1);
            rd(status_event_pkg::IDX_REG_COND + 4'(n), 16'h0001);
            rd(status_event_pkg::IDX_INST_EVENT, 16'h0001 << (1 + n));
            rd(status_event_pkg::IDX_REG_EVENT + 4'(n), 16'h0001);
            rd(status_event_pkg::IDX_REG_EVENT + 4'(n), 16'h0000);
            rd(status_event_pkg::IDX_REG_EVENT + 4'((n + 1) % N_OUT), 16'h0000);
            set_mode(n, status_event_pkg::MODE_CV);
            idle(2);
            set_mode(n, status_event_pkg::MODE_UNREG);
            idle(2);
            rd(status_event_pkg::IDX_REG_COND + 4'(n), 16'h0003);
            rd(status_event_pkg::IDX_REG_EVENT + 4'(n), 16'h0003);
            set_mode(n, status_event_pkg::MODE_OFF);
            idle(2);
            rd(status_event_pkg::IDX_REG_COND + 4'(n), 16'h0000);
            rd(status_event_pkg::IDX_INST_EVENT, 16'h0001 << (1 + n));
            idle(2);
            rd(status_event_pkg::IDX_QUESTIONABLE_GROUP_EVENT, 16'h2000);
            idle(2);
            rd(status_event_pkg::IDX_QUESTIONABLE_GROUP_EVENT, 16'h0000);
            idle(3);
            sbq(1'b0);
        end
        // new event at the very edge of its clearing read
        set_mode(0, status_event_pkg::MODE_CV);
        idle(2);
        exp_q.push_back(16'h0000);
        @(posedge clk_sys);
        cmd <= '{valid: 1'b1, write: 1'b0, index: status_event_pkg::IDX_REG_EVENT, wdata: 16'h0};
        output_mode[0] <= status_event_pkg::MODE_CC;
        idle(2);
        rd(status_event_pkg::IDX_REG_EVENT, 16'h0001);
        set_mode(0, status_event_pkg::MODE_CV);
        idle(5);
        // pipelined summaries re-latch, so pulse until the chain is drained
        repeat (3) begin
            @(posedge clk_sys);
            clear_status <= 1'b1;
            idle(1);
        end
        idle(2);
        rd(status_event_pkg::IDX_REG_EVENT, 16'h0000);
        rd(status_event_pkg::IDX_INST_EVENT, 16'h0000);
        rd(status_event_pkg::IDX_QUESTIONABLE_GROUP_EVENT, 16'h0000);
        rd(status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE, 16'h2000);
        rd(status_event_pkg::IDX_INST_ENABLE, 16'h000e);
        rd(status_event_pkg::IDX_REG_ENABLE, 16'h0003);
        wr(status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE, 16'h0000);
        rd(status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE, 16'h0000);
        wr(status_event_pkg::IDX_REG_ENABLE + 4'h2, 16'h0001);
        set_mode(2, status_event_pkg::MODE_CC);
        idle(2);
        set_mode(2, status_event_pkg::MODE_CV);
        idle(5);
        rd(status_event_pkg::IDX_INST_EVENT, 16'h0000);
        rd(status_event_pkg::IDX_REG_EVENT + 4'h2, 16'h0002);
        set_mode(1, status_event_pkg::MODE_CV);
        idle(2);
        set_mode(1, status_event_pkg::MODE_CC);
        idle(5);
        sbq(1'b0);
        wr(status_event_pkg::IDX_QUESTIONABLE_GROUP_ENABLE, 16'h2000);
        idle(2);
        sbq(1'b1);
        idle(3);
        if (exp_q.size() != 0) begin
            fail_count++;
            $display("mismatch rsp.valid expected %0d more seen none", exp_q.size());
        end
        test_done();
    end
endmodule : status_event_hierarchy_bench

/* File: status_event_pkg.sv */
// constants and carrier types for the questionable status hierarchy
package status_event_pkg;

    localparam int          REG_W            = 16;
    localparam int          NUM_OUTPUTS      = 3;
    localparam int          IDX_W            = 4;

    // register indices on the command port
    localparam logic [3:0]  IDX_QUESTIONABLE_GROUP_EVENT   = 4'h0;
    localparam logic [3:0]  IDX_QUESTIONABLE_GROUP_ENABLE  = 4'h1;
    localparam logic [3:0]  IDX_INST_EVENT   = 4'h2;
    localparam logic [3:0]  IDX_INST_ENABLE  = 4'h3;
    localparam logic [3:0]  IDX_REG_EVENT    = 4'h4;
    localparam logic [3:0]  IDX_REG_COND     = 4'h7;
    localparam logic [3:0]  IDX_REG_ENABLE   = 4'ha;

    // field positions
    localparam int          QUESTIONABLE_GROUP_SUMMARY_BIT = 13;
    localparam int          FIRST_OUTPUT_BIT = 1;
    localparam int          VOLT_LOSS_BIT    = 0;
    localparam int          CURR_LOSS_BIT    = 1;

    // bits that exist in each event register
    localparam logic [15:0] QUESTIONABLE_GROUP_IMPL_MASK   = 16'h2000;
    localparam logic [15:0] INST_IMPL_MASK   = 16'h000e;
    localparam logic [15:0] REG_IMPL_MASK    = 16'h0003;
    localparam logic [15:0] ALL_BITS_MASK    = 16'hffff;

    // values after reset
    localparam logic [15:0] EVENT_RESET      = 16'h0000;
    localparam logic [15:0] ENABLE_RESET     = 16'h0000;
    localparam logic [1:0]  COND_RESET       = 2'h0;
    localparam logic [15:0] READ_ZERO        = 16'h0000;

    // live regulation mode encoding: bit 1 voltage, bit 0 current
    localparam logic [1:0]  MODE_OFF         = 2'h0;
    localparam logic [1:0]  MODE_CC          = 2'h1;
    localparam logic [1:0]  MODE_CV          = 2'h2;
    localparam logic [1:0]  MODE_UNREG       = 2'h3;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [IDX_W-1:0]  index;
        logic [REG_W-1:0]  wdata;
    } reg_cmd_t;

    typedef struct packed {
        logic              valid;
        logic [REG_W-1:0]  data;
    } reg_rsp_t;

endpackage : status_event_pkg
